/* rtl/rtc_flags_irq_and_power_ctrl.sv */
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
module rtc_flags_irq_and_power_ctrl
	import rtc_flags_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        RESET_N,
	input  wire logic [7:0]  ADDR,
	input  wire logic        BANK,
	input  wire logic [7:0]  WR_DATA,
	input  wire logic        WR_STB,
	input  wire logic        RD_STB,
	output logic      [7:0]  RD_DATA,
	input  wire logic        HOST_RESET_IN,
	input  wire logic [15:0] DIVIDER_TAPS,
	input  wire logic [3:0]  RATE_SELECT,
	input  wire logic        ALARM_MATCH,
	input  wire logic        UPDATE_END,
	input  wire logic        UPDATE_BUSY,
	input  wire logic        BATTERY_LOW,
	input  wire logic        DATE_ALARM_ENABLED,
	input  wire logic        BATTERY_POR,
	input  wire logic        STANDBY_SUPPLY,
	input  wire logic        STANDBY_POR,
	output logic             IRQ_OUT_N,
	output logic             POWER_ON_N_O,
	output logic             POWER_ON_N_OE,
	output logic             UPDATE_HALT,
	output logic             BINARY_FORMAT_SELECT,
	output logic             HOUR_FORMAT_SELECT,
	output logic             CRYSTAL_LOAD_SELECT
);

	state_t     state_ff;
	state_t     nxt_state;
	host_req_t  req;
	logic [7:0] cmos_mem [0:255];
	logic [7:0] cmos_rd;
	logic       cmos_hit;
	logic       tap_now;
	logic [2:0] events;
	logic       sel_mode;
	logic       sel_flags;
	logic       sel_date;
	logic       sel_recovery;

	function automatic logic is_cmos(input logic bank, input logic [7:0] addr);
		if (bank) begin
			return addr <= CMOS_BANK1_HI;
		end else begin
			return ((addr >= CMOS_BANK0_LO) && (addr <= CMOS_BANK0_HI)) ||
				(addr == CMOS_BANK0_EXTRA);
		end
	endfunction

	// Storage never sits above 0x7f in either bank, so one bank bit and seven offset
	// bits address both banks in one array without overlap.
	function automatic logic [7:0] cmos_index(input logic bank, input logic [7:0] addr);
		return {bank, addr[6:0]};
	endfunction

	// The flag byte and the interrupt pin must agree, so both use this one term.
	function automatic logic any_pending(input logic [2:0] flags, input logic [2:0] en);
		return |(flags & en);
	endfunction

	function automatic logic [7:0] flag_byte(input logic [2:0] flags, input logic [2:0] en);
		return {any_pending(flags, en), flags, 4'h0};
	endfunction

	function automatic logic [7:0] mode_byte(input state_t s);
		logic [7:0] b;
		b = BYTE_ZERO;
		b[MC_HALT_BIT] = s.halt;
		b[MC_PIE_BIT:MC_UIE_BIT] = s.irq_en;
		b[MC_BINARY_BIT] = s.binary_format_select;
		b[MC_HOUR24_BIT] = s.hour_format_select;
		b[MC_DSE_BIT] = MC_DSE_VALUE;
		return b;
	endfunction

	function automatic logic [7:0] date_byte(input logic       valid,
		input logic [5:0] date, input logic show);
		logic [7:0] b;
		b = BYTE_ZERO;
		b[7] = valid;
		if (show) begin
			b[5:0] = date;
		end
		return b;
	endfunction

	// Stay-off is tested first, so a forbidden setting of both bits keeps power off.
	function automatic pwr_state_t por_target(input logic [7:0] prc);
		pwr_state_t t;
		t = PWR_IDLE;
		if (prc[PR_STAY_OFF_BIT]) begin
			t = PWR_FLOAT;
		end else if (prc[PR_POWER_ON_BIT]) begin
			t = PWR_DRIVE;
		end
		return t;
	endfunction

	// Register decode for bank 0; bank 1 carries only storage.
	always_comb begin
		sel_mode     = 1'b0;
		sel_flags    = 1'b0;
		sel_date     = 1'b0;
		sel_recovery = 1'b0;
		if (req.bank) begin
			sel_mode = 1'b0;
		end else if (req.addr == MODE_CONTROL_OFS) begin
			sel_mode = 1'b1;
		end else if (req.addr == IRQ_FLAGS_OFS) begin
			sel_flags = 1'b1;
		end else if (req.addr == ALARM_DATE_OFS) begin
			sel_date = 1'b1;
		end else if (req.addr == PWR_RECOVERY_OFS) begin
			sel_recovery = 1'b1;
		end
	end

	assign req = '{addr: ADDR, bank: BANK, wr_data: WR_DATA, wr_stb: WR_STB, rd_stb: RD_STB};
	assign cmos_hit = is_cmos(req.bank, req.addr);
	assign tap_now  = DIVIDER_TAPS[RATE_SELECT];

	always_comb begin
		events = 3'b000;
		events[SRC_PERIODIC] = (RATE_SELECT != RATE_OFF) && tap_now && !state_ff.tap_prev;
		events[SRC_ALARM]  = ALARM_MATCH;
		events[SRC_UPDATE] = UPDATE_END;
	end

	// CMOS always open.
	// The storage is not touched by any reset, as a battery would keep it.
	always_ff @(posedge SYS_CLK) begin
		if (req.wr_stb && cmos_hit) begin
			cmos_mem[cmos_index(req.bank, req.addr)] <= req.wr_data;
		end
	end

	assign cmos_rd = cmos_mem[cmos_index(req.bank, req.addr)];

	always_comb begin
		nxt_state = state_ff;
		nxt_state.rd_data = UNMAPPED_READ;
		nxt_state.tap_prev = tap_now;

		// Register writes. Bank 1 holds only CMOS storage.
		if (req.wr_stb) begin
			if (sel_mode) begin
				nxt_state.halt     = req.wr_data[MC_HALT_BIT];
				nxt_state.irq_en   = req.wr_data[MC_PIE_BIT:MC_UIE_BIT];
				nxt_state.binary_format_select = req.wr_data[MC_BINARY_BIT];
				nxt_state.hour_format_select   = req.wr_data[MC_HOUR24_BIT];
				if (req.wr_data[MC_HALT_BIT] && !state_ff.halt) begin
					nxt_state.irq_en[SRC_UPDATE] = 1'b0;
				end
			end else if (sel_date) begin
				if (!UPDATE_BUSY) begin
					nxt_state.date_alarm = req.wr_data[5:0];
				end
			end else if (sel_recovery) begin
				nxt_state.power_recovery_control = req.wr_data & PR_WRITE_MASK;
			end
		end

		// Register reads; the answer stands in the following cycle only.
		if (req.rd_stb) begin
			if (cmos_hit) begin
				nxt_state.rd_data = cmos_rd;
			end else if (sel_mode) begin
				nxt_state.rd_data = mode_byte(state_ff);
			end else if (sel_flags) begin
				nxt_state.rd_data = flag_byte(state_ff.flags, state_ff.irq_en);
				// read clears.
				// The snapshot is the registered byte, so clearing everything here
				// loses nothing: events of this cycle are added back below.
				nxt_state.flags = 3'b000;
			end else if (sel_date) begin
				// valid flag read.
				// The read shows the old valid bit and sets it for the next read, both only while BATTERY_LOW is clear.
				nxt_state.rd_data = date_byte(state_ff.time_valid_flag && !BATTERY_LOW,
					state_ff.date_alarm, !UPDATE_BUSY && DATE_ALARM_ENABLED);
				nxt_state.time_valid_flag = 1'b1;
			end else if (sel_recovery) begin
				nxt_state.rd_data = state_ff.power_recovery_control;
			end
		end

		if (BATTERY_LOW) begin
			nxt_state.time_valid_flag = 1'b0;
		end

		// host reset.
		// The mode format bits, halt and date alarm are left alone on purpose.
		if (HOST_RESET_IN) begin
			nxt_state.flags  = 3'b000;
			nxt_state.irq_en = 3'b000;
		end

		// flags set regardless.
		// Events win over a clear in the same cycle so no event is lost.
		nxt_state.flags = nxt_state.flags | events;

		if (ALARM_MATCH && !STANDBY_SUPPLY &&
			state_ff.power_recovery_control[PR_REMEMBER_BIT]) begin
			nxt_state.alarm_missed = 1'b1;
		end

		case (state_ff.pwr_state)
			PWR_IDLE: begin
				if (STANDBY_POR) begin
					nxt_state.pwr_state = por_target(state_ff.power_recovery_control);
				end

				// A remembered alarm waits here until the supply is back.
				// drive on return.
				if (STANDBY_SUPPLY && state_ff.alarm_missed &&
					!state_ff.power_recovery_control[PR_STAY_OFF_BIT]) begin
					nxt_state.pwr_state = PWR_DRIVE;
					nxt_state.alarm_missed = 1'b0;
				end
			end
			PWR_DRIVE: begin
				// Main power is up once the host reset is seen, so the request ends.
				if (HOST_RESET_IN) begin
					nxt_state.pwr_state = PWR_IDLE;
				end
			end
			PWR_FLOAT: begin
				nxt_state.pwr_state = PWR_IDLE;
			end
			default: begin
				nxt_state.pwr_state = PWR_IDLE;
			end
		endcase

		if (BATTERY_POR) begin
			nxt_state.power_recovery_control = PR_RESET;
			nxt_state.alarm_missed = 1'b0;
		end

		// any source both set.
		// The pin is taken from the next state so that it and the flag byte
		// change on the same edge.
		nxt_state.irq_out_n = !any_pending(nxt_state.flags, nxt_state.irq_en);
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_ff <= '{
				halt:                   1'b0,
				irq_en:                 3'b000,
				binary_format_select:   1'b0,
				hour_format_select:     1'b0,
				flags:                  3'b000,
				time_valid_flag:        1'b0,
				date_alarm:             DATE_ALARM_RESET,
				power_recovery_control: PR_RESET,
				alarm_missed:           1'b0,
				pwr_state:              PWR_IDLE,
				tap_prev:               1'b0,
				rd_data:                UNMAPPED_READ,
				irq_out_n:              1'b1
			};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign RD_DATA              = state_ff.rd_data;
	assign IRQ_OUT_N            = state_ff.irq_out_n;
	assign POWER_ON_N_O         = 1'b0;
	assign POWER_ON_N_OE        = (state_ff.pwr_state == PWR_DRIVE);
	assign UPDATE_HALT          = state_ff.halt;
	assign BINARY_FORMAT_SELECT = state_ff.binary_format_select;
	assign HOUR_FORMAT_SELECT   = state_ff.hour_format_select;
	assign CRYSTAL_LOAD_SELECT  = state_ff.power_recovery_control[PR_CRYSTAL_BIT];

endmodule // rtc_flags_irq_and_power_ctrl

/* rtl/rtc_flags_pkg.sv */
package rtc_flags_pkg;

	localparam logic [7:0] MODE_CONTROL_OFS   = 8'h0b;
	localparam logic [7:0] IRQ_FLAGS_OFS      = 8'h0c;
	localparam logic [7:0] ALARM_DATE_OFS     = 8'h0d;
	localparam logic [7:0] PWR_RECOVERY_OFS   = 8'h7e;
	localparam logic [7:0] CMOS_BANK0_LO      = 8'h0e;
	localparam logic [7:0] CMOS_BANK0_HI      = 8'h7c;
	localparam logic [7:0] CMOS_BANK0_EXTRA   = 8'h7f;
	localparam logic [7:0] CMOS_BANK1_HI      = 8'h7f;
	localparam logic [7:0] UNMAPPED_READ      = 8'h00;
	localparam logic [7:0] BYTE_ZERO          = 8'h00;
	localparam logic [5:0] DATE_ALARM_RESET   = 6'h00;
	localparam logic [3:0] RATE_OFF           = 4'h0;

	// Mode control bit positions.
	localparam int MC_HALT_BIT   = 7;
	localparam int MC_PIE_BIT    = 6;
	localparam int MC_AIE_BIT    = 5;
	localparam int MC_UIE_BIT    = 4;
	localparam int MC_BINARY_BIT = 2;
	localparam int MC_HOUR24_BIT = 1;
	localparam int MC_DSE_BIT    = 0;
	localparam logic MC_DSE_VALUE = 1'b0;

	// Power recovery control bit positions.
	localparam int PR_REMEMBER_BIT = 0;
	localparam int PR_STAY_OFF_BIT = 1;
	localparam int PR_POWER_ON_BIT = 2;
	localparam int PR_CRYSTAL_BIT  = 7;
	localparam logic [7:0] PR_WRITE_MASK = 8'h87;
	localparam logic [7:0] PR_RESET      = 8'h00;

	// Order of sources in a three bit vector: periodic, alarm, update end.
	localparam int SRC_PERIODIC = 2;
	localparam int SRC_ALARM    = 1;
	localparam int SRC_UPDATE   = 0;

	typedef struct packed {
		logic [7:0] addr;
		logic       bank;
		logic [7:0] wr_data;
		logic       wr_stb;
		logic       rd_stb;
	} host_req_t;

	typedef enum logic [1:0] {
		PWR_IDLE  = 2'b00,
		PWR_DRIVE = 2'b01,
		PWR_FLOAT = 2'b11
	} pwr_state_t;

	typedef struct packed {
		logic       halt;
		logic [2:0] irq_en;
		logic       binary_format_select;
		logic       hour_format_select;
		logic [2:0] flags;
		logic       time_valid_flag;
		logic [5:0] date_alarm;
		logic [7:0] power_recovery_control;
		logic       alarm_missed;
		pwr_state_t pwr_state;
		logic       tap_prev;
		logic [7:0] rd_data;
		logic       irq_out_n;
	} state_t;

endpackage

/* tb/rtc_flags_monitor.sv */
`timescale 1ns/10ps
module rtc_flags_monitor
	import rtc_flags_pkg::*;
(
	input wire logic       SYS_CLK,
	input wire logic       RESET_N,
	input wire logic [7:0] ADDR,
	input wire logic       BANK,
	input wire logic [7:0] WR_DATA,
	input wire logic       WR_STB,
	input wire logic       RD_STB,
	input wire logic [7:0] RD_DATA,
	input wire logic       HOST_RESET_IN,
	input wire logic       UPDATE_BUSY,
	input wire logic       DATE_ALARM_ENABLED,
	input wire logic       IRQ_OUT_N,
	input wire logic       BINARY_FORMAT_SELECT,
	input wire logic       HOUR_FORMAT_SELECT,
	input wire logic       CRYSTAL_LOAD_SELECT
);
	wire rd_fl = RD_STB && !BANK && ADDR == IRQ_FLAGS_OFS;
	wire rd_mc = RD_STB && !BANK && ADDR == MODE_CONTROL_OFS;
	wire rd_ad = RD_STB && !BANK && ADDR == ALARM_DATE_OFS;
	wire rd_pr = RD_STB && !BANK && ADDR == PWR_RECOVERY_OFS;
	wire wr_mc = WR_STB && !BANK && ADDR == MODE_CONTROL_OFS;
	wire wr_pr = WR_STB && !BANK && ADDR == PWR_RECOVERY_OFS;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	a_flag_low_zero: assert property (
		$past(rd_fl) |-> RD_DATA[3:0] == 4'h0) else $error("flag low bits set");
	a_mode_reserved: assert property (
		$past(rd_mc) |-> !RD_DATA[3] && RD_DATA[MC_DSE_BIT] == MC_DSE_VALUE)
		else $error("mode reserved bits set");
	a_pr_reserved: assert property (
		$past(rd_pr) |-> RD_DATA[6:3] == 4'h0) else $error("recovery reserved set");
	a_date_b6_zero: assert property (
		$past(rd_ad) |-> !RD_DATA[6]) else $error("alarm date b6 set");
	a_busy_blocks: assert property (
		$past(rd_ad && UPDATE_BUSY) |-> RD_DATA[5:0] == 6'h00)
		else $error("date visible while busy");
	a_date_off_zero: assert property (
		$past(rd_ad && !DATE_ALARM_ENABLED) |-> RD_DATA[5:0] == 6'h00)
		else $error("date visible while disabled");
	a_hostrst_quiet: assert property (
		HOST_RESET_IN ##1 HOST_RESET_IN |=> IRQ_OUT_N) else $error("irq after host reset");
	a_format_hold: assert property (
		!$past(wr_mc) |-> $stable(BINARY_FORMAT_SELECT) && $stable(HOUR_FORMAT_SELECT))
		else $error("format changed without write");
	a_format_write: assert property (
		$past(wr_mc) |-> BINARY_FORMAT_SELECT == $past(WR_DATA[MC_BINARY_BIT])
		&& HOUR_FORMAT_SELECT == $past(WR_DATA[MC_HOUR24_BIT])) else $error("format write lost");
	a_crystal_write: assert property (
		$past(wr_pr) |-> CRYSTAL_LOAD_SELECT == $past(WR_DATA[PR_CRYSTAL_BIT]))
		else $error("crystal write lost");
endmodule // rtc_flags_monitor
bind rtc_flags_irq_and_power_ctrl rtc_flags_monitor i_mon (.SYS_CLK(SYS_CLK),
	.RESET_N(RESET_N), .ADDR(ADDR), .BANK(BANK), .WR_DATA(WR_DATA), .WR_STB(WR_STB),
	.RD_STB(RD_STB), .RD_DATA(RD_DATA), .HOST_RESET_IN(HOST_RESET_IN),
	.UPDATE_BUSY(UPDATE_BUSY), .DATE_ALARM_ENABLED(DATE_ALARM_ENABLED),
	.IRQ_OUT_N(IRQ_OUT_N), .BINARY_FORMAT_SELECT(BINARY_FORMAT_SELECT),
	.HOUR_FORMAT_SELECT(HOUR_FORMAT_SELECT), .CRYSTAL_LOAD_SELECT(CRYSTAL_LOAD_SELECT));

/* tb/rtc_host_model.sv */
`timescale 1ns/10ps
module rtc_host_model
	import rtc_flags_pkg::*;
(
	input  wire logic clk,
	output host_req_t req
);
	// Expected read data, oldest first; the watcher in the bench consumes it.
	logic [7:0] exp_q[$];
	initial req = '0;
	// Each strobe drops before the next request, so no edge ever sees two.
	task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{a, b, d, 1'b1, 1'b0};
		@(posedge clk);
		req <= '0;
	endtask
	task automatic rd(input logic b, input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		req <= '{a, b, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		req <= '0;
	endtask
endmodule // rtc_host_model

/* tb/test_rtc_flags_irq_and_power_ctrl.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module test_rtc_flags_irq_and_power_ctrl
	import rtc_flags_pkg::*;
;
	logic clk = 0, rst_n = 0, host_rst = 0, alarm = 0, upd_end = 0, busy = 0;
	logic batt_low = 0, date_en = 1, batt_por = 0, stby = 1, stby_por = 0, rd_d = 0;
	logic [15:0] taps = '0;
	logic [3:0]  rate = 4'h1;
	logic [7:0]  rd_data, exp_v, v;
	logic [5:0]  d;
	logic        irq_n, pwr_o, pwr_oe, halt, bin, h24, xtal;
	host_req_t   req;
	int          seed = 68, fail_count = 0, n_checks = 0;
	always #5 clk = ~clk;
	rtc_host_model host (.clk(clk), .req(req));
	rtc_flags_irq_and_power_ctrl i_dut (.SYS_CLK(clk), .RESET_N(rst_n), .ADDR(req.addr),
		.BANK(req.bank), .WR_DATA(req.wr_data), .WR_STB(req.wr_stb), .RD_STB(req.rd_stb),
		.RD_DATA(rd_data), .HOST_RESET_IN(host_rst), .DIVIDER_TAPS(taps), .RATE_SELECT(rate),
		.ALARM_MATCH(alarm), .UPDATE_END(upd_end), .UPDATE_BUSY(busy), .BATTERY_LOW(batt_low),
		.DATE_ALARM_ENABLED(date_en), .BATTERY_POR(batt_por), .STANDBY_SUPPLY(stby),
		.STANDBY_POR(stby_por), .IRQ_OUT_N(irq_n), .POWER_ON_N_O(pwr_o),
		.POWER_ON_N_OE(pwr_oe), .UPDATE_HALT(halt), .BINARY_FORMAT_SELECT(bin),
		.HOUR_FORMAT_SELECT(h24), .CRYSTAL_LOAD_SELECT(xtal));
	// Read data stands only in the cycle after the read edge, so it is taken there.
	always @(posedge clk) begin
		if (rd_d) begin
			exp_v = host.exp_q.pop_front();
			`CHK("rd_data", exp_v, rd_data)
		end
		rd_d <= req.rd_stb;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic hr();
		@(posedge clk);
		host_rst <= 1;
		repeat (2) @(posedge clk);
		host_rst <= 0;
	endtask
	task automatic ev(input int i);
		@(posedge clk);
		case (i)
			0: upd_end <= 1;
			1: alarm <= 1;
			default: taps[rate] <= 1;
		endcase
		@(posedge clk);
		{upd_end, alarm, taps} <= '0;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#500000;
		fail_count++;
		conclude();
	end
	initial begin
		rate = 4'((($random(seed) & 32'h7fffffff) % 15) + 1);
		d = 6'($random(seed));
		v = 8'($random(seed));
		repeat (12) @(posedge clk);
		rst_n <= 1;
		host.rd(0, 8'h0c, 8'h00);
		host.wr(0, 8'h0b, 8'h0f);
		host.rd(0, 8'h0b, 8'h06);
		hr();
		host.rd(0, 8'h0b, 8'h06);
		host.wr(0, 8'h0b, 8'h90);
		host.rd(0, 8'h0b, 8'h80);
		`CHK("halt", 1'b1, halt)
		host.wr(0, 8'h0b, 8'h00);
		$display("done mode");
		for (int i = 0; i < 3; i++) begin
			ev(i);
			host.rd(0, 8'h0c, 8'h10 << i);
			ev(i);
			host.wr(0, 8'h0b, 8'h10 << i);
			tick(2);
			`CHK("irq_set", 1'b0, irq_n)
			host.rd(0, 8'h0c, 8'h80 | (8'h10 << i));
			tick(2);
			`CHK("irq_clr", 1'b1, irq_n)
			host.wr(0, 8'h0b, 8'h00);
		end
		fork
			host.rd(0, 8'h0c, 8'h00);
			ev(1);
		join
		host.rd(0, 8'h0c, 8'h20);
		$display("done flags");
		host.wr(0, 8'h0d, {2'b11, d});
		host.rd(0, 8'h0d, {2'b00, d});
		host.rd(0, 8'h0d, {2'b10, d});
		busy <= 1;
		host.wr(0, 8'h0d, 8'h00);
		host.rd(0, 8'h0d, 8'h80);
		host.wr(0, 8'h0e, v);
		host.wr(0, 8'h7f, ~v);
		host.wr(1, 8'h00, v ^ 8'h5a);
		host.rd(0, 8'h0e, v);
		host.rd(0, 8'h7f, ~v);
		host.rd(1, 8'h00, v ^ 8'h5a);
		busy <= 0;
		host.rd(0, 8'h00, UNMAPPED_READ);
		hr();
		host.rd(0, 8'h0d, {2'b10, d});
		date_en <= 0;
		host.rd(0, 8'h0d, 8'h80);
		batt_low <= 1;
		host.rd(0, 8'h0d, 8'h00);
		batt_low <= 0;
		$display("done date");
		host.wr(0, 8'h7e, 8'hff);
		host.rd(0, 8'h7e, 8'h87);
		host.wr(0, 8'h7e, 8'h04);
		stby_por <= 1;
		tick(1);
		stby_por <= 0;
		tick(3);
		`CHK("pwr_on", 1'b1, pwr_oe)
		`CHK("pwr_low", 1'b0, pwr_o)
		hr();
		host.wr(0, 8'h7e, 8'h02);
		stby_por <= 1;
		tick(1);
		stby_por <= 0;
		tick(3);
		`CHK("pwr_float", 1'b0, pwr_oe)
		host.wr(0, 8'h7e, 8'h01);
		stby <= 0;
		ev(1);
		stby <= 1;
		tick(3);
		`CHK("pwr_remember", 1'b1, pwr_oe)
		hr();
		batt_por <= 1;
		tick(1);
		batt_por <= 0;
		host.rd(0, 8'h7e, 8'h00);
		tick(4);
		$display("done power");
		conclude();
	end
endmodule // test_rtc_flags_irq_and_power_ctrl
